// [src/fps_alu.sv]
// eight-bit arithmetic and logic unit with status update
`timescale 1ns/1ps
module fps_alu (
  input wire logic [3:0] fn,
  input wire logic [fps_pkg::DATA_W-1:0] a,
  input wire logic [fps_pkg::DATA_W-1:0] b,
  input wire logic [fps_pkg::ST_W-1:0] status_in,
  output logic [fps_pkg::DATA_W-1:0] result,
  output logic [fps_pkg::ST_W-1:0] status_out,
  output logic zero
);
  logic cin;
  logic is_sub;
  logic carry_in;
  logic [7:0] b_op;
  logic [8:0] sum;
  logic [4:0] half;
  logic ovf;
  logic lo_adj;
  logic hi_adj;
  logic [8:0] daa1;
  logic [8:0] daa2;
  logic rotate;

  assign cin = status_in[fps_pkg::ST_C];
  assign is_sub = (fn == fps_pkg::ALU_SUB) || (fn == fps_pkg::ALU_SBC);
  // carry set means no borrow on subtract
  assign carry_in = (fn == fps_pkg::ALU_SUB) ? 1'b1 :
    ((fn == fps_pkg::ALU_ADC) || (fn == fps_pkg::ALU_SBC)) ? cin : 1'b0;
  assign b_op = is_sub ? ~b : b;
  assign sum = {1'b0, a} + {1'b0, b_op} + {8'h00, carry_in};
  assign half = {1'b0, a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, carry_in};
  assign ovf = (a[7] == b_op[7]) && (sum[7] != a[7]);
  assign lo_adj = (a[3:0] > fps_pkg::BCD_MAX) ||
                  status_in[fps_pkg::ST_AC];
  assign daa1 = {1'b0, a} + {1'b0, lo_adj ? fps_pkg::BCD_LO_ADJ : 8'h00};
  assign hi_adj = daa1[8] || cin || (daa1[7:4] > fps_pkg::BCD_MAX);
  assign daa2 = daa1 + {1'b0, hi_adj ? fps_pkg::BCD_HI_ADJ : 8'h00};
  assign rotate = (fn == fps_pkg::ALU_RR) || (fn == fps_pkg::ALU_RRC) ||
                  (fn == fps_pkg::ALU_RL) || (fn == fps_pkg::ALU_RLC);
  assign zero = (result == 8'h00);

  always_comb begin // see [RULE16]
    result = a;
    status_out = status_in;
    case (fn) // see [RULE17]
      fps_pkg::ALU_ADD, fps_pkg::ALU_ADC,
      fps_pkg::ALU_SUB, fps_pkg::ALU_SBC: begin
        result = sum[7:0];
        status_out[fps_pkg::ST_C] = sum[8];
        status_out[fps_pkg::ST_AC] = half[4];
        status_out[fps_pkg::ST_OV] = ovf;
      end
      fps_pkg::ALU_DAA: begin
        result = daa2[7:0];
        status_out[fps_pkg::ST_C] = hi_adj;
      end
      fps_pkg::ALU_AND: result = a & b;
      fps_pkg::ALU_OR: result = a | b;
      fps_pkg::ALU_XOR: result = a ^ b;
      fps_pkg::ALU_CPL: result = ~a;
      fps_pkg::ALU_RR: result = {a[0], a[7:1]};
      fps_pkg::ALU_RRC: begin
        result = {cin, a[7:1]};
        status_out[fps_pkg::ST_C] = a[0];
      end
      fps_pkg::ALU_RL: result = {a[6:0], a[7]};
      fps_pkg::ALU_RLC: begin
        result = {a[6:0], cin};
        status_out[fps_pkg::ST_C] = a[7];
      end
      fps_pkg::ALU_INC: result = a + 8'h01;
      fps_pkg::ALU_DEC: result = a - 8'h01;
      default: result = a;
    endcase
    // rotates leave the zero flag alone
    if (!rotate) begin
      status_out[fps_pkg::ST_Z] = (result == 8'h00);
    end
  end
endmodule

// [src/fps_core.sv]
// instruction sequencer: four-phase timing, program counter, return stack
//
// Summary of operation
// [RULE1] four phases per instruction cycle
// [RULE2] counter advances and fetch happens at first phase
// [RULE3] fetch overlaps execute; extended ops take two
// [RULE4] jumps and calls cost one extra cycle
// [RULE5] counter steps by one unless flow changes
// [RULE6] counter is bank bit, five high, eight low
// [RULE7] low byte writable; jumps stay in page
// [RULE8] low byte write inserts one dummy cycle
// [RULE9] taken skip replaces prefetched word with dummy
// [RULE10] jump, call, interrupt, reset load address directly
// [RULE11] eight-level hidden stack of counter values
// [RULE12] call and interrupt push; returns pop
// [RULE13] reset leaves stack pointer at empty top
// [RULE14] full stack holds interrupt acknowledge until return
// [RULE15] call on full stack overflows anyway
// [RULE16] eight-bit unit writes result and status
// [RULE17] add, subtract, decimal, logic, rotate, step, tests
// [RULE18] reset loads counter with address zero
// [RULE19] overflow wraps; return on empty ignored
`timescale 1ns/1ps
module fps_core (
  input wire logic clk,
  input wire logic arst_n,
  output logic [fps_pkg::ADDR_W-1:0] pm_addr,
  output logic pm_rd,
  input wire logic [fps_pkg::WORD_W-1:0] pm_data,
  output logic [3:0] phase_clocks,
  output logic [fps_pkg::WORD_W-1:0] exec_word,
  output logic exec_valid,
  input wire logic [2:0] op_kind,
  input wire logic [fps_pkg::PC_W-1:0] op_target,
  input wire logic code_bank_select_bit,
  input wire logic alu_en,
  input wire logic [3:0] alu_fn,
  input wire logic [fps_pkg::DATA_W-1:0] alu_a,
  input wire logic [fps_pkg::DATA_W-1:0] alu_b,
  output logic [fps_pkg::DATA_W-1:0] alu_result,
  output logic [fps_pkg::ST_W-1:0] status,
  input wire logic pc_low_byte_wr_en,
  input wire logic [fps_pkg::DATA_W-1:0] pc_low_byte_wr_data,
  output logic [fps_pkg::DATA_W-1:0] pc_low_byte,
  input wire logic int_req,
  input wire logic [fps_pkg::PC_W-1:0] int_vector,
  output logic int_pending,
  output logic int_ack,
  output logic int_done
);
  fps_pkg::fps_phase_t phase_reg;
  fps_pkg::fps_phase_t phase_next;
  logic [3:0] phase_clk_reg;
  logic [fps_pkg::ADDR_W-1:0] pc_reg;
  logic [fps_pkg::ADDR_W-1:0] pc_next;
  logic [fps_pkg::ADDR_W-1:0] pc_inc;
  logic [fps_pkg::WORD_W-1:0] fetch_reg;
  logic [fps_pkg::WORD_W-1:0] exec_word_reg;
  logic dummy_reg;
  logic hold_reg;
  logic int_pend_reg;
  logic int_ack_reg;
  logic int_done_reg;
  logic [fps_pkg::DATA_W-1:0] alu_res_reg;
  logic [fps_pkg::ST_W-1:0] status_reg;

  logic at_t4;
  logic take;
  logic skip_hit;
  logic do_jump;
  logic do_call;
  logic do_ret;
  logic do_interrupt_return_op;
  logic do_ext;
  logic do_pcl;
  logic do_int;
  logic redirect;
  logic seq_step;
  logic alu_wr;
  logic [fps_pkg::DATA_W-1:0] alu_out;
  logic [fps_pkg::ST_W-1:0] alu_status;
  logic alu_zero;
  logic [fps_pkg::ADDR_W-1:0] stk_top;
  logic stk_full;
  logic stk_empty;
  logic stk_push;
  logic stk_pop;

  // phase sequencer: one pass PHASE_CLOCKS is one instruction cycle
  always_comb begin // see [RULE1]
    case (phase_reg)
      fps_pkg::PH_T1: phase_next = fps_pkg::PH_T2;
      fps_pkg::PH_T2: phase_next = fps_pkg::PH_T3;
      fps_pkg::PH_T3: phase_next = fps_pkg::PH_T4;
      fps_pkg::PH_T4: phase_next = fps_pkg::PH_T1;
      default: phase_next = fps_pkg::PH_T1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= fps_pkg::PH_T1;
      phase_clk_reg <= fps_pkg::PHASE_T1_ONEHOT;
    end else begin
      phase_reg <= phase_next;
      phase_clk_reg <= 4'h1 << phase_next; // see [RULE1]
    end
  end

  assign phase_clocks = phase_clk_reg;
  assign at_t4 = (phase_reg == fps_pkg::PH_T4);

  // every decision is made at the last phase, the counter moves on T1
  assign take = at_t4 && !dummy_reg && !hold_reg;
  assign skip_hit = take && // see [RULE9]
    ((op_kind == fps_pkg::OP_SKZ && alu_zero) ||
     (op_kind == fps_pkg::OP_SKNZ && !alu_zero));
  assign do_jump = take && (op_kind == fps_pkg::OP_JUMP);
  assign do_call = take && (op_kind == fps_pkg::OP_CALL);
  assign do_ret = take && fps_pkg::fps_is_return(op_kind);
  assign do_interrupt_return_op = take && (op_kind == fps_pkg::OP_INTERRUPT_RETURN_OP);
  assign do_ext = take && (op_kind == fps_pkg::OP_EXT);
  // a flow-changing op outranks a data write to the low byte
  assign do_pcl = take && pc_low_byte_wr_en && !skip_hit &&
                  !fps_pkg::fps_is_transfer(op_kind);
  assign redirect = do_jump || do_call || do_ret || skip_hit || do_pcl;
  // acknowledge waits while all eight levels are in use (see [RULE14])
  assign do_int = at_t4 && !hold_reg && int_pend_reg && !stk_full &&
                  !redirect && !do_ext;
  assign seq_step = at_t4 && !hold_reg && !redirect && !do_int && !do_ext;

  // bank bit stays fixed on a plain step; only loads may change it
  assign pc_inc = {pc_reg[fps_pkg::ADDR_W-1],
                   pc_reg[fps_pkg::PC_W-1:0] + fps_pkg::PC_ONE}; // [RULE6]

  always_comb begin
    pc_next = pc_inc; // see [RULE5]
    if (hold_reg || do_ext) begin
      pc_next = pc_reg; // see [RULE3]
    end else if (do_jump || do_call) begin
      pc_next = {code_bank_select_bit, op_target}; // see [RULE10]
    end else if (do_ret) begin
      pc_next = stk_top; // see [RULE12]
    end else if (do_pcl) begin
      // page-local jump: upper bits untouched (see [RULE7])
      pc_next = {pc_reg[fps_pkg::ADDR_W-1:fps_pkg::DATA_W],
                 pc_low_byte_wr_data};
    end else if (do_int) begin
      pc_next = {1'b0, int_vector}; // see [RULE10]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_reg <= fps_pkg::RESET_PC; // see [RULE18]
      dummy_reg <= 1'b1;
      hold_reg <= 1'b0;
      exec_word_reg <= 16'h0000;
    end else if (at_t4) begin
      pc_reg <= pc_next; // see [RULE2]
      // discarded prefetch becomes a dummy (see [RULE4] [RULE8] [RULE9])
      dummy_reg <= redirect || do_int;
      hold_reg <= do_ext; // see [RULE3]
      exec_word_reg <= fetch_reg; // see [RULE3]
    end
  end

  // word for pc_reg is read during T1 while the previous one executes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_reg <= 16'h0000;
    end else if (phase_reg == fps_pkg::PH_T1) begin
      fetch_reg <= pm_data; // see [RULE2]
    end
  end

  assign pm_addr = pc_reg;
  assign pm_rd = (phase_reg == fps_pkg::PH_T1); // see [RULE2]
  assign exec_word = exec_word_reg;
  assign exec_valid = !dummy_reg && !hold_reg;
  assign pc_low_byte = pc_reg[fps_pkg::DATA_W-1:0]; // see [RULE7]

  // interrupt flag: a new request wins over the acknowledge clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_pend_reg <= 1'b0;
      int_ack_reg <= 1'b0;
      int_done_reg <= 1'b0;
    end else begin
      int_pend_reg <= int_req || (int_pend_reg && !do_int); // [RULE14]
      int_ack_reg <= do_int;
      int_done_reg <= do_interrupt_return_op;
    end
  end

  assign int_pending = int_pend_reg;
  assign int_ack = int_ack_reg;
  assign int_done = int_done_reg;

  // the return address is whatever was prefetched but not executed
  assign stk_push = do_call || do_int; // see [RULE12]
  assign stk_pop = do_ret; // see [RULE12]

  fps_stack u_stack (
    .clk(clk),
    .arst_n(arst_n),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(pc_reg),
    .top_data(stk_top),
    .full(stk_full),
    .empty(stk_empty)
  );

  fps_alu u_alu (
    .fn(alu_fn),
    .a(alu_a),
    .b(alu_b),
    .status_in(status_reg),
    .result(alu_out),
    .status_out(alu_status),
    .zero(alu_zero)
  );

  assign alu_wr = take && alu_en;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alu_res_reg <= 8'h00;
      status_reg <= fps_pkg::STATUS_RESET;
    end else if (alu_wr) begin
      alu_res_reg <= alu_out; // see [RULE16]
      status_reg <= alu_status; // see [RULE16]
    end
  end

  assign alu_result = alu_res_reg;
  assign status = status_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_phase_ring: assert property ( // see [RULE1]
    at_t4 |=> phase_clocks == 4'h1 ##1 phase_clocks == 4'h2
      ##1 phase_clocks == 4'h4 ##1 phase_clocks == 4'h8)
    else $error("phase sequence broken");
  chk_pc_steady: assert property ( // see [RULE2]
    !at_t4 |=> $stable(pm_addr))
    else $error("counter moved outside the phase boundary");
  chk_seq_step: assert property ( // see [RULE5]
    seq_step |=> pm_addr == {$past(pc_reg[13]), $past(pc_reg[12:0]) + 13'h1})
    else $error("sequential step was not plus one");
  chk_ext_hold: assert property ( // see [RULE3]
    do_ext |=> (!exec_valid && $stable(pm_addr))[*4])
    else $error("extended op did not take a second cycle");
  chk_branch_dummy: assert property ( // see [RULE4]
    (do_jump || do_call || do_ret) |=> (!exec_valid)[*4])
    else $error("branch without extra cycle");
  chk_jump_load: assert property ( // see [RULE10]
    (do_jump || do_call) |=>
      pm_addr == {$past(code_bank_select_bit), $past(op_target)})
    else $error("jump target not loaded");
  chk_pcl_page: assert property ( // see [RULE7]
    do_pcl |=> pm_addr[13:8] == $past(pc_reg[13:8]) &&
      pm_addr[7:0] == $past(pc_low_byte_wr_data) && !exec_valid)
    else $error("low byte write left the page or skipped dummy");
  chk_skip_dummy: assert property ( // see [RULE9]
    skip_hit |=> (!exec_valid)[*4] ##1 $past(pm_addr, 4) != pm_addr)
    else $error("taken skip did not discard prefetch");
  chk_ret_restore: assert property ( // see [RULE12]
    (do_ret && !stk_empty) |=> pm_addr == $past(stk_top))
    else $error("return did not restore the counter");
  chk_int_holdoff: assert property ( // see [RULE14]
    (int_pending && stk_full && !do_ret) |=> !int_ack)
    else $error("interrupt acknowledged on a full stack");
  chk_int_vector: assert property ( // see [RULE10]
    int_ack |-> pm_addr == {1'b0, $past(int_vector)} && int_pending == $past(int_req))
    else $error("interrupt acknowledge without vector load");

  cov_call: cover property (do_call ##[1:40] do_ret);
  cov_int_ack: cover property (int_ack);
  cov_skip: cover property (skip_hit);
  cov_overflow: cover property (do_call && stk_full);
endmodule

// [src/fps_pkg.sv]
// shared constants, types and decode helpers for the fetch/pc/stack core
package fps_pkg;
  localparam int PC_W = 13;
  localparam int ADDR_W = 14;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int CNT_W = 4;
  localparam int ST_W = 4;
  localparam logic [ADDR_W-1:0] RESET_PC = 14'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [3:0] PHASE_T1_ONEHOT = 4'h1;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [ST_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [DATA_W-1:0] BCD_LO_ADJ = 8'h06;
  localparam logic [DATA_W-1:0] BCD_HI_ADJ = 8'h60;
  localparam logic [3:0] BCD_MAX = 4'h9;
  // status field positions
  localparam int ST_C = 0;
  localparam int ST_AC = 1;
  localparam int ST_Z = 2;
  localparam int ST_OV = 3;

  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b10,
    PH_T4 = 2'b11
  } fps_phase_t;

  typedef enum logic [2:0] {
    OP_PLAIN = 3'b000,
    OP_EXT = 3'b001,
    OP_JUMP = 3'b010,
    OP_CALL = 3'b011,
    OP_RET = 3'b100,
    OP_INTERRUPT_RETURN_OP = 3'b101,
    OP_SKZ = 3'b110,
    OP_SKNZ = 3'b111
  } fps_op_t;

  typedef enum logic [3:0] {
    ALU_ADD = 4'b0000,
    ALU_ADC = 4'b0001,
    ALU_SUB = 4'b0010,
    ALU_SBC = 4'b0011,
    ALU_DAA = 4'b0100,
    ALU_AND = 4'b0101,
    ALU_OR = 4'b0110,
    ALU_XOR = 4'b0111,
    ALU_CPL = 4'b1000,
    ALU_RR = 4'b1001,
    ALU_RRC = 4'b1010,
    ALU_RL = 4'b1011,
    ALU_RLC = 4'b1100,
    ALU_INC = 4'b1101,
    ALU_DEC = 4'b1110,
    ALU_PASS = 4'b1111
  } fps_alu_fn_t;

  // operations that change flow through the stack or a direct load
  function automatic logic fps_is_transfer(input logic [2:0] op);
    fps_is_transfer = (op == OP_JUMP) || (op == OP_CALL) ||
                      (op == OP_RET) || (op == OP_INTERRUPT_RETURN_OP);
  endfunction

  function automatic logic fps_is_return(input logic [2:0] op);
    fps_is_return = (op == OP_RET) || (op == OP_INTERRUPT_RETURN_OP);
  endfunction
endpackage

// [src/fps_stack.sv]
// eight-level circular return-address stack, hidden from software
`timescale 1ns/1ps
module fps_stack (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [fps_pkg::ADDR_W-1:0] push_data,
  output logic [fps_pkg::ADDR_W-1:0] top_data,
  output logic full,
  output logic empty
);
  logic [fps_pkg::ADDR_W-1:0] mem_reg [fps_pkg::STACK_DEPTH];
  logic [fps_pkg::SP_W-1:0] sp_reg;
  logic [fps_pkg::CNT_W-1:0] cnt_reg;
  logic [fps_pkg::SP_W-1:0] sp_top;
  logic do_pop;

  assign sp_top = sp_reg - 3'h1;
  assign top_data = mem_reg[sp_top];
  assign full = (cnt_reg == fps_pkg::CNT_FULL);
  assign empty = (cnt_reg == 4'h0);
  // an empty stack ignores a return: pointer stays put (see [RULE19])
  assign do_pop = pop && !push && !empty;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_reg <= fps_pkg::SP_RESET; // see [RULE13]
      cnt_reg <= 4'h0;
    end else if (push) begin
      // when full the slot at sp is the oldest entry (see [RULE15])
      sp_reg <= sp_reg + 3'h1; // see [RULE19]
      if (!full) begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end else if (do_pop) begin
      sp_reg <= sp_top;
      cnt_reg <= cnt_reg - 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < fps_pkg::STACK_DEPTH; gi++) begin : g_slot
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          mem_reg[gi] <= fps_pkg::RESET_PC;
        end else if (push && sp_reg == gi[fps_pkg::SP_W-1:0]) begin
          mem_reg[gi] <= push_data;
        end
      end
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_overflow_wrap: assert property ( // see [RULE15]
    (push && full) |=> full && sp_reg == $past(sp_reg) + 3'h1)
    else $error("push on full stack did not wrap");
  chk_empty_pop_hold: assert property ( // see [RULE19]
    (pop && !push && empty) |=> empty && $stable(sp_reg))
    else $error("pop on empty stack moved the pointer");
endmodule

// [verif/fps_core_bench.sv]
// self-checking bench for the fetch, program counter and stack core
`timescale 1ns/1ps
module fps_core_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] op_kind = fps_pkg::OP_PLAIN;
  logic [12:0] op_target = 13'h0000;
  logic code_bank_select_bit = 1'b0;
  logic alu_en = 1'b0;
  logic [3:0] alu_fn = 4'h0;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  logic pc_low_byte_wr_en = 1'b0;
  logic [7:0] pc_low_byte_wr_data = 8'h00;
  logic int_req = 1'b0;
  logic [12:0] int_vector = 13'h0040;
  logic [13:0] pm_addr;
  logic pm_rd;
  logic [15:0] pm_data;
  logic [3:0] phase_clocks;
  logic [15:0] exec_word;
  logic exec_valid;
  logic [7:0] alu_result;
  logic [3:0] status;
  logic [7:0] pc_low_byte;
  logic int_pending;
  logic int_ack;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [13:0] ret_q [0:8];

  always #2.5 clk = ~clk;

  fps_core fps_core_inst (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data), .phase_clocks(phase_clocks),
    .exec_word(exec_word), .exec_valid(exec_valid), .op_kind(op_kind),
    .op_target(op_target), .code_bank_select_bit(code_bank_select_bit),
    .alu_en(alu_en), .alu_fn(alu_fn), .alu_a(alu_a), .alu_b(alu_b),
    .alu_result(alu_result), .status(status),
    .pc_low_byte_wr_en(pc_low_byte_wr_en),
    .pc_low_byte_wr_data(pc_low_byte_wr_data), .pc_low_byte(pc_low_byte),
    .int_req(int_req), .int_vector(int_vector), .int_pending(int_pending),
    .int_ack(int_ack), .int_done());
  fps_prog_mem fps_prog_mem_inst (.clk(clk), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_data(pm_data));

  function automatic logic [15:0] word_at(input logic [13:0] a);
    word_at = {2'h2, a};
  endfunction

  task automatic report_and_stop();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // ops are only taken at the close of an executing fourth phase
  task automatic wait_t4();
    for (int i = 0; i < 40; i++) begin
      if (phase_clocks === 4'h8 && exec_valid === 1'b1) begin
        return;
      end
      tick(1);
    end
    n_mismatch++;
    $display("FAIL %0t no executing fourth phase", $time);
    report_and_stop();
  endtask

  task automatic issue(input logic [2:0] kind, input logic [12:0] tgt,
                       input logic bank);
    wait_t4();
    op_kind = kind;
    op_target = tgt;
    code_bank_select_bit = bank;
    tick(1);
    op_kind = fps_pkg::OP_PLAIN;
    pc_low_byte_wr_en = 1'b0;
    alu_en = 1'b0;
  endtask

  task automatic chk_redirect(input logic [13:0] dest);
    cmp(16'(exec_valid), 16'h0000, "no dummy after redirect");
    cmp(16'(pm_addr), 16'(dest), "redirect address");
    tick(4);
    cmp(16'(exec_valid), 16'h0001, "not valid after dummy");
    cmp(exec_word, word_at(dest), "word at destination");
  endtask

  task automatic t_reset();
    tick(2);
    cmp(16'(pm_addr), 16'h0000, "address in reset");
    cmp(16'(phase_clocks), 16'h0001, "phase in reset");
    cmp(16'(pc_low_byte), 16'h0000, "low byte in reset");
    cmp(16'(int_pending), 16'h0000, "pending in reset");
    arst_n = 1'b1;
    for (int i = 1; i <= 8; i++) begin
      tick(1);
      cmp(16'(phase_clocks), 16'(4'h1 << (i % 4)), "phase");
      cmp(16'(pm_rd), 16'(i % 4 == 0), "fetch strobe");
      if (i == 4) begin
        cmp(exec_word, word_at(14'h0000), "reset vector");
      end
    end
  endtask

  task automatic t_seq();
    logic [13:0] a;
    for (int k = 0; k < 3; k++) begin
      wait_t4();
      a = pm_addr;
      issue(fps_pkg::OP_PLAIN, 13'h0000, 1'b0);
      cmp(exec_word, word_at(a), "sequential word");
      cmp(16'(pm_addr), 16'(a + 14'h1), "step by one");
    end
  endtask

  task automatic t_jump_page();
    logic [13:0] a;
    pc_low_byte_wr_en = 1'b1;
    pc_low_byte_wr_data = 8'h55;
    issue(fps_pkg::OP_JUMP, 13'h1abc, 1'b1);
    chk_redirect(14'h3abc);
    wait_t4();
    a = pm_addr;
    pc_low_byte_wr_en = 1'b1;
    pc_low_byte_wr_data = 8'h3c;
    issue(fps_pkg::OP_PLAIN, 13'h0000, 1'b0);
    cmp(16'(pc_low_byte), 16'h003c, "low byte readback");
    chk_redirect({a[13:8], 8'h3c});
  endtask

  task automatic t_skip();
    logic [13:0] a;
    alu_fn = fps_pkg::ALU_AND;
    alu_a = 8'h00;
    alu_b = 8'h00;
    wait_t4();
    a = pm_addr;
    issue(fps_pkg::OP_SKNZ, 13'h0000, 1'b0);
    cmp(16'(exec_valid), 16'h0001, "untaken skip dummied");
    cmp(exec_word, word_at(a), "untaken skip word");
    wait_t4();
    a = pm_addr;
    issue(fps_pkg::OP_SKZ, 13'h0000, 1'b0);
    chk_redirect(a + 14'h1);
  endtask

  task automatic t_alu();
    // fn, a, b, result; order matters because carry runs through rows
    logic [27:0] tbl [15] = '{28'h0ff0100, 28'h1010103, 28'h5f03c30,
      28'h40a0a10, 28'h2050302, 28'h3050302, 28'h6500555, 28'h7a5ff5a,
      28'h80f0ff0, 28'h9010180, 28'ha010180, 28'hb808001, 28'hc808001,
      28'hdffff00, 28'he0000ff};
    logic [27:0] e;
    for (int k = 0; k < 15; k++) begin
      e = tbl[k];
      alu_en = 1'b1;
      alu_fn = e[27:24];
      alu_a = e[23:16];
      alu_b = e[15:8];
      issue(fps_pkg::OP_PLAIN, 13'h0000, 1'b0);
      cmp(16'(alu_result), 16'(e[7:0]), "alu result");
      if (e[27:24] < 4'h9 || e[27:24] > 4'hc) begin
        cmp(16'(status[fps_pkg::ST_Z]), 16'(e[7:0] == 8'h00), "zero");
      end
      if (k == 0) begin
        cmp(16'(status[fps_pkg::ST_C]), 16'h0001, "carry");
      end
    end
  endtask

  task automatic t_int();
    logic [13:0] r;
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    cmp(16'(int_pending), 16'h0001, "request not latched");
    wait_t4();
    r = pm_addr;
    tick(1);
    cmp(16'(int_ack), 16'h0001, "no acknowledge");
    cmp(16'(pm_addr), 16'h0040, "vector address");
    issue(fps_pkg::OP_INTERRUPT_RETURN_OP, 13'h0000, 1'b0);
    chk_redirect(r);
  endtask

  task automatic t_stack();
    for (int k = 0; k < 9; k++) begin
      wait_t4();
      ret_q[k] = pm_addr;
      issue(fps_pkg::OP_CALL, 13'h0400 + 13'(k * 16), 1'b0);
      chk_redirect(14'h0400 + 14'(k * 16));
    end
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    wait_t4();
    tick(1);
    cmp(16'(int_ack), 16'h0000, "ack with full stack");
    cmp(16'(int_pending), 16'h0001, "request dropped");
    issue(fps_pkg::OP_RET, 13'h0000, 1'b0);
    cmp(16'(pm_addr), 16'(ret_q[8]), "newest return");
    tick(4);
    cmp(16'(int_ack), 16'h0001, "held ack not given");
    cmp(16'(pm_addr), 16'h0040, "held vector");
    issue(fps_pkg::OP_INTERRUPT_RETURN_OP, 13'h0000, 1'b0);
    chk_redirect(ret_q[8]);
    for (int k = 7; k >= 1; k--) begin
      issue(fps_pkg::OP_RET, 13'h0000, 1'b0);
      chk_redirect(ret_q[k]);
    end
  endtask

  initial begin
    t_reset();
    t_seq();
    t_jump_page();
    t_skip();
    t_alu();
    t_int();
    t_stack();
    report_and_stop();
  end
endmodule

// [verif/fps_prog_mem.sv]
// program memory model: each word carries the address it was read from
`timescale 1ns/1ps
module fps_prog_mem (
  input wire logic clk,
  input wire logic [fps_pkg::ADDR_W-1:0] pm_addr,
  input wire logic pm_rd,
  output logic [fps_pkg::WORD_W-1:0] pm_data
);
  logic [fps_pkg::WORD_W-1:0] last_reg;
  wire logic [fps_pkg::WORD_W-1:0] word = {2'h2, pm_addr};
  // outside the read phase the bus shows junk, so a late sample is caught
  assign pm_data = pm_rd ? word : ~last_reg;
  always_ff @(posedge clk) begin
    if (pm_rd) begin
      last_reg <= word;
    end
  end
endmodule
